/* File: ecs_pkg.sv */
// package: constants, offsets and service codes of the encoder configuration and object services
package ecs_pkg;
  // assembly and connection points
  localparam logic [7:0] ASM_CONFIG = 8'h64;
  localparam logic [7:0] ASM_POS = 8'h65;
  localparam logic [7:0] ASM_POS_FLAGS = 8'h66;
  localparam logic [7:0] ASM_POS_SPEED = 8'h67;
  localparam int REC_LEN = 28;
  // record byte positions
  localparam logic [4:0] B_STEPS = 5'h04;
  localparam logic [4:0] B_TOTAL = 5'h08;
  localparam logic [4:0] B_DIR = 5'h0C;
  localparam logic [4:0] B_SCALE = 5'h0D;
  localparam logic [4:0] B_ROUND = 5'h0E;
  localparam logic [4:0] B_NUM = 5'h10;
  localparam logic [4:0] B_DEN = 5'h14;
  localparam logic [4:0] B_SPEED = 5'h18;
  localparam logic [4:0] B_LAST = 5'h1B;
  // service codes
  localparam logic [7:0] SVC_RESET = 8'h05;
  localparam logic [7:0] SVC_GET = 8'h0E;
  localparam logic [7:0] SVC_SET = 8'h10;
  localparam logic [7:0] SVC_RESTORE = 8'h15;
  localparam logic [7:0] SVC_SAVE = 8'h16;
  // class attributes
  localparam logic [7:0] CA_REV = 8'h01;
  localparam logic [7:0] CA_MAXINST = 8'h02;
  localparam logic [7:0] CA_NINST = 8'h03;
  localparam logic [7:0] CA_MAXATTR = 8'h06;
  localparam logic [7:0] CA_FW = 8'h64;
  localparam logic [31:0] V_REV = 32'h0000_0002;
  localparam logic [31:0] V_ONE = 32'h0000_0001;
  localparam logic [31:0] V_MAXATTR = 32'h0000_0064;
  // firmware version word, value arbitrary
  localparam logic [31:0] V_FW = 32'h0001_0000;
  // instance attributes
  localparam logic [7:0] IA_DIR = 8'h0C;
  localparam logic [7:0] IA_SCALE = 8'h0E;
  localparam logic [7:0] IA_STEPS = 8'h10;
  localparam logic [7:0] IA_TOTAL = 8'h11;
  localparam logic [7:0] IA_ROUND = 8'h12;
  localparam logic [7:0] IA_SPEED = 8'h19;
  localparam logic [7:0] IA_NUM = 8'h20;
  localparam logic [7:0] IA_DEN = 8'h21;
  // factory defaults
  localparam logic [31:0] D_STEPS = 32'h0004_0000;
  localparam logic [31:0] D_TOTAL = 32'h4000_0000;
  localparam logic [31:0] D_NUM = 32'h0000_0001;
  localparam logic [31:0] D_DEN = 32'h0000_0001;
  localparam logic [15:0] D_SPEED = 16'h1F0F;
  // status codes of the answer
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BADSVC = 8'h08;
  localparam logic [7:0] ST_BADATTR = 8'h14;
  // wishbone register offsets
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_STAT = 4'h1;
  localparam logic [3:0] R_STEPS = 4'h2;
  localparam logic [3:0] R_TOTAL = 4'h3;
  localparam logic [3:0] R_NUM = 4'h4;
  localparam logic [3:0] R_DEN = 4'h5;
  localparam logic [3:0] R_MISC = 4'h6;
  localparam int CTRL_GENERIC = 0;
  localparam int CTRL_CFGEN = 1;
  localparam int CTRL_INIT = 2;
  // parameter set, packed for storage
  localparam int PSET_W = 147;
  typedef enum logic [1:0] {
    ECS_IDLE = 2'b00,
    ECS_EXEC = 2'b01,
    ECS_NVWAIT = 2'b11,
    ECS_RESP = 2'b10
  } ecs_state_t;
endpackage

/* File: ecs_nvstore.sv */
// non-volatile parameter copy with a one-cycle done handshake
`timescale 1ns/1ns
module ecs_nvstore (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request
  input wire logic save_i,
  input wire logic load_i,
  input wire logic [ecs_pkg::PSET_W-1:0] data_i,
  // answer
  output logic done_o,
  output logic [ecs_pkg::PSET_W-1:0] data_o
);
  logic [ecs_pkg::PSET_W-1:0] mem_reg, mem_next;
  logic [ecs_pkg::PSET_W-1:0] out_reg, out_next;
  logic done_reg, done_next;
  always_comb begin
    mem_next = mem_reg;
    out_next = out_reg;
    done_next = save_i | load_i;
    if (save_i) begin
      mem_next = data_i;
    end
    if (load_i) begin
      out_next = mem_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_reg <= {ecs_pkg::D_SPEED, 1'b0, 1'b0, 1'b0, ecs_pkg::D_DEN, ecs_pkg::D_NUM,
                  ecs_pkg::D_TOTAL, ecs_pkg::D_STEPS};
      out_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      out_reg <= out_next;
      done_reg <= done_next;
    end
  end
  assign done_o = done_reg;
  assign data_o = out_reg;
endmodule

/* File: ecs_recparse.sv */
// byte-wise parser of the 28-byte configuration record
`timescale 1ns/1ns
module ecs_recparse (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // record byte stream
  input wire logic start_i,
  input wire logic byte_vld_i,
  input wire logic [7:0] byte_i,
  // parsed fields
  output logic done_o,
  output logic [ecs_pkg::PSET_W-1:0] pset_o
);
  logic [4:0] idx_reg, idx_next;
  logic [ecs_pkg::PSET_W-1:0] p_reg, p_next;
  logic done_reg, done_next;
  always_comb begin
    idx_next = idx_reg;
    p_next = p_reg;
    done_next = 1'b0;
    if (start_i) begin
      idx_next = '0;
    end else if (byte_vld_i) begin
      // unused bytes and bits fall through untouched
      if (idx_reg >= ecs_pkg::B_STEPS && idx_reg < ecs_pkg::B_TOTAL) begin
        p_next[{idx_reg[1:0], 3'b000} +: 8] = byte_i;
      end else if (idx_reg >= ecs_pkg::B_TOTAL && idx_reg < ecs_pkg::B_DIR) begin
        p_next[8'd32 + {idx_reg[1:0], 3'b000} +: 8] = byte_i;
      end else if (idx_reg >= ecs_pkg::B_NUM && idx_reg < ecs_pkg::B_DEN) begin
        p_next[8'd64 + {idx_reg[1:0], 3'b000} +: 8] = byte_i;
      end else if (idx_reg >= ecs_pkg::B_DEN && idx_reg < ecs_pkg::B_SPEED) begin
        p_next[8'd96 + {idx_reg[1:0], 3'b000} +: 8] = byte_i;
      end else if (idx_reg == ecs_pkg::B_DIR) begin
        p_next[128] = byte_i[0];
      end else if (idx_reg == ecs_pkg::B_SCALE) begin
        p_next[129] = byte_i[0];
      end else if (idx_reg == ecs_pkg::B_ROUND) begin
        p_next[130] = byte_i[0];
      end else if (idx_reg == ecs_pkg::B_SPEED) begin
        p_next[138:131] = byte_i;
      end else if (idx_reg == ecs_pkg::B_SPEED + 5'h01) begin
        p_next[146:139] = byte_i;
      end
      if (idx_reg == ecs_pkg::B_LAST) begin
        done_next = 1'b1;
        idx_next = '0;
      end else begin
        idx_next = idx_reg + 5'h01;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_reg <= '0;
      p_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      p_reg <= p_next;
      done_reg <= done_next;
    end
  end
  assign done_o = done_reg;
  assign pset_o = p_reg;
endmodule

/* File: ecs_top.sv */
// encoder configuration record intake and position-sensor object services
// Function
// - configuration arrives through assembly 100
// - with CTRL_GENERIC clear, instances 101, 102, 103 activate the record; with it set, CTRL_CFGEN decides
// - with CTRL_GENERIC clear, no-config variants leave the record inactive
// - multi-byte fields sit least significant first
// - bit 0 of bytes 12-14 hold flags
// - record is fixed, bytes 0 to 27
// - fetch and apply record during initialization
// - every object parameter readable and writable
// - class reset restores factory defaults
// - get service returns addressed attribute value
// - restore reloads last saved parameters
// - save writes parameters to non-volatile copy
// - set service updates addressed instance attribute
// - class revision 2, instances 1 and 1
// - highest class attribute 0064h, attribute 100 firmware
// - steps per turn defaults to 00040000h
`timescale 1ns/1ns
module ecs_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // connection set-up and record stream
  input wire logic [7:0] io_instance_i,
  input wire logic noconfig_i,
  input wire logic rec_vld_i,
  input wire logic [7:0] rec_byte_i,
  // explicit request
  input wire logic req_vld_i,
  input wire logic [7:0] req_service_i,
  input wire logic req_class_i,
  input wire logic [7:0] req_attr_i,
  input wire logic [31:0] req_data_i,
  // explicit answer
  output logic rsp_vld_o,
  output logic [7:0] rsp_status_o,
  output logic [31:0] rsp_data_o,
  // applied configuration
  output logic cfg_active_o,
  output logic count_direction_o,
  output logic scaling_o,
  output logic round_axis_o,
  output logic [31:0] steps_per_turn_o
);
  localparam logic [ecs_pkg::PSET_W-1:0] PDEF = {ecs_pkg::D_SPEED, 1'b0, 1'b0, 1'b0,
    ecs_pkg::D_DEN, ecs_pkg::D_NUM, ecs_pkg::D_TOTAL, ecs_pkg::D_STEPS};

  function automatic logic [31:0] attr_get(input logic [ecs_pkg::PSET_W-1:0] p,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ecs_pkg::IA_STEPS: v = p[31:0];
      ecs_pkg::IA_TOTAL: v = p[63:32];
      ecs_pkg::IA_NUM: v = p[95:64];
      ecs_pkg::IA_DEN: v = p[127:96];
      ecs_pkg::IA_DIR: v = {31'h0, p[128]};
      ecs_pkg::IA_SCALE: v = {31'h0, p[129]};
      ecs_pkg::IA_ROUND: v = {31'h0, p[130]};
      ecs_pkg::IA_SPEED: v = {16'h0, p[146:131]};
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic attr_known(input logic [7:0] a);
    return a == ecs_pkg::IA_STEPS || a == ecs_pkg::IA_TOTAL || a == ecs_pkg::IA_NUM ||
           a == ecs_pkg::IA_DEN || a == ecs_pkg::IA_DIR || a == ecs_pkg::IA_SCALE ||
           a == ecs_pkg::IA_ROUND || a == ecs_pkg::IA_SPEED;
  endfunction

  ecs_pkg::ecs_state_t st_reg, st_next;
  logic [ecs_pkg::PSET_W-1:0] pset_reg, pset_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic cfg_reg, cfg_next;
  logic init_done_reg, init_done_next;
  logic init_pend_reg, init_pend_next;
  logic [7:0] svc_reg, svc_next;
  logic cls_reg, cls_next;
  logic [7:0] attr_reg, attr_next;
  logic [31:0] wdat_reg, wdat_next;
  logic rsp_vld_reg, rsp_vld_next;
  logic [7:0] rsp_st_reg, rsp_st_next;
  logic [31:0] rsp_dat_reg, rsp_dat_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic nv_save, nv_load, nv_done, rec_done;
  logic [ecs_pkg::PSET_W-1:0] nv_q, rec_q;
  logic [31:0] busw;

  ecs_recparse u_parse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(init_pend_reg & ~cfg_reg),
    .byte_vld_i(rec_vld_i & cfg_reg & init_pend_reg),
    .byte_i(rec_byte_i),
    .done_o(rec_done),
    .pset_o(rec_q)
  );

  ecs_nvstore u_nv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .save_i(nv_save),
    .load_i(nv_load),
    .data_i(pset_reg),
    .done_o(nv_done),
    .data_o(nv_q)
  );

  // wishbone: byte-lane merge of written control word
  always_comb begin
    busw = {30'h0, ctrl_reg};
    for (int i = 0; i < 4; i++) begin
      if (sel_i[i]) begin
        busw[i*8 +: 8] = dat_i[i*8 +: 8];
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    pset_next = pset_reg;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    init_done_next = init_done_reg;
    init_pend_next = init_pend_reg;
    svc_next = svc_reg;
    cls_next = cls_reg;
    attr_next = attr_reg;
    wdat_next = wdat_reg;
    rsp_vld_next = 1'b0;
    rsp_st_next = rsp_st_reg;
    rsp_dat_next = rsp_dat_reg;
    ack_next = 1'b0;
    dat_next = dat_reg;
    nv_save = 1'b0;
    nv_load = 1'b0;
    // record activation from CTRL_CFGEN when CTRL_GENERIC is set, else from the selected instance
    if (ctrl_reg[ecs_pkg::CTRL_GENERIC]) begin
      cfg_next = ctrl_reg[ecs_pkg::CTRL_CFGEN];
    end else begin
      cfg_next = !noconfig_i && (io_instance_i == ecs_pkg::ASM_POS ||
                 io_instance_i == ecs_pkg::ASM_POS_FLAGS ||
                 io_instance_i == ecs_pkg::ASM_POS_SPEED);
    end
    // initialization fetch of assembly 100 record
    if (init_pend_reg && rec_done) begin
      pset_next = rec_q;
      init_pend_next = 1'b0;
      init_done_next = 1'b1;
    end else if (init_pend_reg && !cfg_reg) begin
      init_pend_next = 1'b0;
      init_done_next = 1'b1;
    end
    // wishbone slave
    if (cyc_i && stb_i && !ack_reg) begin
      ack_next = 1'b1;
      dat_next = '0;
      unique case (adr_i[5:2])
        ecs_pkg::R_CTRL: dat_next = {30'h0, ctrl_reg};
        ecs_pkg::R_STAT: dat_next = {29'h0, init_pend_reg, init_done_reg, cfg_reg};
        ecs_pkg::R_STEPS: dat_next = pset_reg[31:0];
        ecs_pkg::R_TOTAL: dat_next = pset_reg[63:32];
        ecs_pkg::R_NUM: dat_next = pset_reg[95:64];
        ecs_pkg::R_DEN: dat_next = pset_reg[127:96];
        ecs_pkg::R_MISC: dat_next = {13'h0, pset_reg[146:128]};
        default: dat_next = '0;
      endcase
      if (we_i && adr_i[5:2] == ecs_pkg::R_CTRL) begin
        ctrl_next = busw[1:0];
        if (busw[ecs_pkg::CTRL_INIT]) begin
          init_pend_next = 1'b1;
          init_done_next = 1'b0;
        end
      end
    end
    // explicit service engine
    unique case (st_reg)
      ecs_pkg::ECS_IDLE: begin
        if (req_vld_i) begin
          svc_next = req_service_i;
          cls_next = req_class_i;
          attr_next = req_attr_i;
          wdat_next = req_data_i;
          st_next = ecs_pkg::ECS_EXEC;
        end
      end
      ecs_pkg::ECS_EXEC: begin
        rsp_st_next = ecs_pkg::ST_OK;
        rsp_dat_next = '0;
        st_next = ecs_pkg::ECS_RESP;
        if (svc_reg == ecs_pkg::SVC_GET && cls_reg) begin
          unique case (attr_reg)
            ecs_pkg::CA_REV: rsp_dat_next = ecs_pkg::V_REV;
            ecs_pkg::CA_MAXINST: rsp_dat_next = ecs_pkg::V_ONE;
            ecs_pkg::CA_NINST: rsp_dat_next = ecs_pkg::V_ONE;
            ecs_pkg::CA_MAXATTR: rsp_dat_next = ecs_pkg::V_MAXATTR;
            ecs_pkg::CA_FW: rsp_dat_next = ecs_pkg::V_FW;
            default: rsp_st_next = ecs_pkg::ST_BADATTR;
          endcase
        end else if (svc_reg == ecs_pkg::SVC_GET) begin
          rsp_dat_next = attr_get(pset_reg, attr_reg);
          if (!attr_known(attr_reg)) begin
            rsp_st_next = ecs_pkg::ST_BADATTR;
          end
        end else if (svc_reg == ecs_pkg::SVC_SET && !cls_reg) begin
          rsp_st_next = attr_known(attr_reg) ? ecs_pkg::ST_OK : ecs_pkg::ST_BADATTR;
          unique case (attr_reg)
            ecs_pkg::IA_STEPS: pset_next[31:0] = wdat_reg;
            ecs_pkg::IA_TOTAL: pset_next[63:32] = wdat_reg;
            ecs_pkg::IA_NUM: pset_next[95:64] = wdat_reg;
            ecs_pkg::IA_DEN: pset_next[127:96] = wdat_reg;
            ecs_pkg::IA_DIR: pset_next[128] = wdat_reg[0];
            ecs_pkg::IA_SCALE: pset_next[129] = wdat_reg[0];
            ecs_pkg::IA_ROUND: pset_next[130] = wdat_reg[0];
            ecs_pkg::IA_SPEED: pset_next[146:131] = wdat_reg[15:0];
            default: pset_next = pset_reg;
          endcase
        end else if (svc_reg == ecs_pkg::SVC_RESET && cls_reg) begin
          pset_next = PDEF;
        end else if (svc_reg == ecs_pkg::SVC_SAVE) begin
          nv_save = 1'b1;
          st_next = ecs_pkg::ECS_NVWAIT;
        end else if (svc_reg == ecs_pkg::SVC_RESTORE) begin
          nv_load = 1'b1;
          st_next = ecs_pkg::ECS_NVWAIT;
        end else begin
          rsp_st_next = ecs_pkg::ST_BADSVC;
        end
      end
      ecs_pkg::ECS_NVWAIT: begin
        if (nv_done) begin
          if (svc_reg == ecs_pkg::SVC_RESTORE) begin
            pset_next = nv_q;
          end
          st_next = ecs_pkg::ECS_RESP;
        end
      end
      ecs_pkg::ECS_RESP: begin
        rsp_vld_next = 1'b1;
        st_next = ecs_pkg::ECS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ecs_pkg::ECS_IDLE;
      pset_reg <= PDEF;
      ctrl_reg <= '0;
      cfg_reg <= 1'b0;
      init_done_reg <= 1'b0;
      init_pend_reg <= 1'b0;
      svc_reg <= '0;
      cls_reg <= 1'b0;
      attr_reg <= '0;
      wdat_reg <= '0;
      rsp_vld_reg <= 1'b0;
      rsp_st_reg <= '0;
      rsp_dat_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      st_reg <= st_next;
      pset_reg <= pset_next;
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      init_done_reg <= init_done_next;
      init_pend_reg <= init_pend_next;
      svc_reg <= svc_next;
      cls_reg <= cls_next;
      attr_reg <= attr_next;
      wdat_reg <= wdat_next;
      rsp_vld_reg <= rsp_vld_next;
      rsp_st_reg <= rsp_st_next;
      rsp_dat_reg <= rsp_dat_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign rsp_vld_o = rsp_vld_reg;
  assign rsp_status_o = rsp_st_reg;
  assign rsp_data_o = rsp_dat_reg;
  assign cfg_active_o = cfg_reg;
  assign steps_per_turn_o = pset_reg[31:0];
  assign count_direction_o = pset_reg[128];
  assign scaling_o = pset_reg[129];
  assign round_axis_o = pset_reg[130];

  // checks
  rev_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ecs_pkg::ECS_EXEC && svc_reg == ecs_pkg::SVC_GET && cls_reg &&
    attr_reg == ecs_pkg::CA_REV |=> ##1 rsp_vld_o && rsp_data_o == ecs_pkg::V_REV)
    else $error("class revision answer wrong");
  maxattr_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ecs_pkg::ECS_EXEC && svc_reg == ecs_pkg::SVC_GET && cls_reg &&
    attr_reg == ecs_pkg::CA_MAXATTR |=> ##1 rsp_data_o == ecs_pkg::V_MAXATTR)
    else $error("highest class attribute answer wrong");
  reset_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ecs_pkg::ECS_EXEC && svc_reg == ecs_pkg::SVC_RESET && cls_reg
    |=> steps_per_turn_o == ecs_pkg::D_STEPS && !count_direction_o)
    else $error("factory reset not applied");
  set_steps_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ecs_pkg::ECS_EXEC && svc_reg == ecs_pkg::SVC_SET && !cls_reg &&
    attr_reg == ecs_pkg::IA_STEPS |=> steps_per_turn_o == $past(wdat_reg))
    else $error("set steps not applied");
  save_before_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_vld_o && (svc_reg == ecs_pkg::SVC_SAVE || svc_reg == ecs_pkg::SVC_RESTORE)
    |-> $past(nv_done, 2))
    else $error("answer before storage finished");
  cfg_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[ecs_pkg::CTRL_GENERIC] && !noconfig_i && io_instance_i == ecs_pkg::ASM_POS
    ##1 !ctrl_reg[ecs_pkg::CTRL_GENERIC] |-> cfg_active_o)
    else $error("record not active for selected instance");
  cfg_noconfig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[ecs_pkg::CTRL_GENERIC] && noconfig_i ##1 !ctrl_reg[ecs_pkg::CTRL_GENERIC]
    |-> !cfg_active_o)
    else $error("record active for no-config instance");
  init_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
    init_pend_reg && rec_done |=> pset_reg == $past(rec_q) && init_done_reg)
    else $error("record not applied at initialization");
  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle");
  save_cov: cover property (@(posedge clk_i) st_reg == ecs_pkg::ECS_NVWAIT ##2 rsp_vld_o);
  init_cov: cover property (@(posedge clk_i) init_pend_reg && rec_done);
  set_cov: cover property (@(posedge clk_i) svc_reg == ecs_pkg::SVC_SET && rsp_vld_o);
endmodule

/* File: ecs_scanner.sv */
// controller model that streams the configuration record
`timescale 1ns/1ns
module ecs_scanner (
  // clock
  input wire logic clk_i,
  // record to send
  input wire logic send_i,
  input wire logic slow_i,
  input wire logic [223:0] rec_i,
  // record stream
  output logic rec_vld_o,
  output logic [7:0] rec_byte_o,
  output logic busy_o
);
  int idx = 28;
  logic ph = 1'b0;
  // heartbeat points this controller uses for its two connection kinds
  localparam int HB_INPUT = 198;
  localparam int HB_LISTEN = 199;
  initial begin
    rec_vld_o = 1'b0;
    rec_byte_o = 8'h00;
  end
  assign busy_o = idx < 28;
  // whole record, never empty, byte 0 first, one byte per strobe
  always @(posedge clk_i) begin
    ph <= ~ph;
    if (send_i) begin
      idx <= 0;
    end
    if (!send_i && idx < 28 && (!slow_i || ph)) begin
      rec_vld_o <= 1'b1;
      rec_byte_o <= rec_i[idx*8 +: 8];
      idx <= idx + 1;
    end else begin
      rec_vld_o <= 1'b0;
      rec_byte_o <= ~rec_byte_o;
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench of the encoder configuration and object services
`timescale 1ns/1ns
module tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, noconfig_i, rec_vld_i, req_vld_i;
  logic req_class_i, rsp_vld_o, cfg_active_o, count_direction_o, scaling_o, round_axis_o;
  logic send, slow, busy;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, req_data_i, rsp_data_o, steps_per_turn_o, q;
  logic [7:0] io_instance_i, rec_byte_i, req_service_i, req_attr_i, rsp_status_o;
  logic [223:0] rec;
  logic [31:0] exp_r [7];
  int miscompares = 0;
  int checks_done = 0;
  typedef struct packed {
    logic [7:0] s; logic c; logic [7:0] a; logic [7:0] st; logic [31:0] d;
  } ecs_row_t;
  ecs_row_t rows [10];

  ecs_top ecs_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .io_instance_i, .noconfig_i, .rec_vld_i, .rec_byte_i, .req_vld_i,
    .req_service_i, .req_class_i, .req_attr_i, .req_data_i, .rsp_vld_o, .rsp_status_o,
    .rsp_data_o, .cfg_active_o, .count_direction_o, .scaling_o, .round_axis_o,
    .steps_per_turn_o);
  ecs_scanner ecs_scanner_inst (.clk_i, .send_i(send), .slow_i(slow), .rec_i(rec),
    .rec_vld_o(rec_vld_i), .rec_byte_o(rec_byte_i), .busy_o(busy));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic pick(input int k);
    return k == 0 ? ack_o : (k == 1 ? rsp_vld_o : !busy);
  endfunction

  // bounded wait, value seen as sampled at the edge
  task automatic wait_on(input int k);
    int n;
    n = 0;
    while (pick(k) !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 60) begin
        miscompares++;
        end_of_test();
      end
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 2'b00, d};
    @(posedge clk_i);
    wait_on(0);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask

  task automatic svc(input logic [7:0] s, input logic c, input logic [7:0] a,
                     input logic [31:0] d);
    {req_vld_i, req_service_i, req_class_i, req_attr_i, req_data_i} <= {1'b1, s, c, a, d};
    @(posedge clk_i);
    req_vld_i <= 1'b0;
    wait_on(1);
    @(posedge clk_i);
  endtask

  // unused bytes all ones, unused flag bits ones except in byte 13, flags dir 0, scale 1, round 1
  function automatic logic [223:0] mkrec(input logic [31:0] st);
    logic [223:0] r;
    r = '1;
    r[32 +: 32] = st;
    r[64 +: 32] = 32'h0048_D140;
    r[96 +: 24] = 24'hFF_01_FE;
    r[128 +: 64] = {32'h0000_0007, 32'h0000_0003};
    r[192 +: 16] = 16'h1F04;
    return r;
  endfunction

  task automatic load(input logic [31:0] st);
    wb(1'b1, ecs_pkg::R_CTRL, 32'h0000_0004);
    rec <= mkrec(st);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    wait_on(2);
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'b1000, 6'h00, 4'hF, 32'h0};
    {req_vld_i, req_service_i, req_class_i, req_attr_i, req_data_i} = '0;
    {io_instance_i, noconfig_i, send, slow, rec} = '0;
    rows = '{
      {ecs_pkg::SVC_GET, 1'b1, ecs_pkg::CA_REV, ecs_pkg::ST_OK, ecs_pkg::V_REV},
      {ecs_pkg::SVC_GET, 1'b1, ecs_pkg::CA_MAXINST, ecs_pkg::ST_OK, ecs_pkg::V_ONE},
      {ecs_pkg::SVC_GET, 1'b1, ecs_pkg::CA_NINST, ecs_pkg::ST_OK, ecs_pkg::V_ONE},
      {ecs_pkg::SVC_GET, 1'b1, ecs_pkg::CA_MAXATTR, ecs_pkg::ST_OK, ecs_pkg::V_MAXATTR},
      {ecs_pkg::SVC_GET, 1'b1, ecs_pkg::CA_FW, ecs_pkg::ST_OK, ecs_pkg::V_FW},
      {ecs_pkg::SVC_GET, 1'b0, ecs_pkg::IA_STEPS, ecs_pkg::ST_OK, ecs_pkg::D_STEPS},
      {ecs_pkg::SVC_GET, 1'b0, ecs_pkg::IA_TOTAL, ecs_pkg::ST_OK, ecs_pkg::D_TOTAL},
      {ecs_pkg::SVC_GET, 1'b0, 8'h7F, ecs_pkg::ST_BADATTR, 32'h0},
      {8'h33, 1'b0, ecs_pkg::IA_STEPS, ecs_pkg::ST_BADSVC, 32'h0},
      {ecs_pkg::SVC_GET, 1'b1, 8'h50, ecs_pkg::ST_BADATTR, 32'h0}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("steps", ecs_pkg::D_STEPS, steps_per_turn_o);
    chk("active", 32'h0, {31'h0, cfg_active_o});
    $display("reset test done");
    foreach (rows[i]) begin
      svc(rows[i].s, rows[i].c, rows[i].a, 32'h0);
      chk("status", {24'h0, rows[i].st}, {24'h0, rsp_status_o});
      if (rows[i].st == ecs_pkg::ST_OK) chk("data", rows[i].d, rsp_data_o);
    end
    $display("service rows done");
    io_instance_i <= ecs_pkg::ASM_POS;
    wb(1'b1, ecs_pkg::R_CTRL, 32'h0000_0001);
    chk("active", 32'h0, {31'h0, cfg_active_o});
    wb(1'b1, ecs_pkg::R_CTRL, 32'h0000_0003);
    chk("active", 32'h1, {31'h0, cfg_active_o});
    wb(1'b1, ecs_pkg::R_CTRL, 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      io_instance_i <= ecs_pkg::ASM_POS + 8'(k % 3);
      noconfig_i <= k > 2;
      repeat (3) @(posedge clk_i);
      chk("active", {31'h0, k < 3}, {31'h0, cfg_active_o});
    end
    $display("activation test done");
    load(32'h0000_0005);
    chk("steps", ecs_pkg::D_STEPS, steps_per_turn_o);
    noconfig_i <= 1'b0;
    slow <= 1'b1;
    load(32'h0001_2345);
    chk("steps", 32'h0001_2345, steps_per_turn_o);
    chk("flags", 32'h6, {29'h0, round_axis_o, scaling_o, count_direction_o});
    wb(1'b1, ecs_pkg::R_STEPS, 32'h0000_0001);
    wb(1'b1, 4'hF, 32'hFFFF_FFFF);
    exp_r = '{32'h3, 32'h0001_2345, 32'h0048_D140, 32'h3, 32'h7, {13'h0, 16'h1F04, 3'b110}, 32'h0};
    for (int k = 0; k < 7; k++) begin
      wb(1'b0, k < 6 ? 4'(k + 1) : 4'hF, 32'h0);
      chk("register", exp_r[k], q);
    end
    $display("record test done");
    svc(ecs_pkg::SVC_SET, 1'b0, ecs_pkg::IA_STEPS, 32'h0000_0100);
    chk("set", 32'h0000_0100, steps_per_turn_o);
    svc(ecs_pkg::SVC_SAVE, 1'b0, 8'h00, 32'h0);
    svc(ecs_pkg::SVC_SET, 1'b0, ecs_pkg::IA_STEPS, 32'h0000_0200);
    svc(ecs_pkg::SVC_RESTORE, 1'b0, 8'h00, 32'h0);
    svc(ecs_pkg::SVC_GET, 1'b0, ecs_pkg::IA_STEPS, 32'h0);
    chk("restore", 32'h0000_0100, rsp_data_o);
    svc(ecs_pkg::SVC_RESET, 1'b1, 8'h00, 32'h0);
    chk("reset", ecs_pkg::D_STEPS, steps_per_turn_o);
    $display("storage test done");
    svc(ecs_pkg::SVC_SET, 1'b0, ecs_pkg::IA_STEPS, 32'h0000_0300);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("steps", ecs_pkg::D_STEPS, steps_per_turn_o);
    chk("active", 32'h0, {31'h0, cfg_active_o});
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
